// ==== verilog/ies_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Incremental encoder speed evaluation with APB register access
module ies_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder tracks
    input wire logic track_a_input,
    input wire logic track_b_input,
    // Released inputs for other functions
    output logic track_a_free,
    output logic track_b_free,
    output logic track_a_other,
    output logic track_b_other,
    // Speed result
    output logic [31:0] speed_out,
    output logic speed_valid,
    output logic edge_timeout
);
    logic [7:0] mode_raw_r;
    logic [13:0] marks_r;
    logic [8:0] config_r;
    logic [31:0] interval_r;
    ies_pkg::ies_mode_type mode;
    logic mode_ok;
    logic a_d_r, b_d_r;
    logic a_edge, b_edge, a_rise;
    logic cnt_en, two_ch, b_used;
    logic signed [31:0] step;
    logic signed [31:0] count_r;
    logic signed [31:0] latch_r;
    logic [31:0] tick_r;
    logic [31:0] gap_r;
    logic [2:0] factor;
    logic div_start_r, div_busy, div_done;
    logic [31:0] div_q;
    logic [31:0] div_num_r;
    logic neg_r;
    logic setup_rd, wr_en;
    logic [31:0] rd_nxt;
    // Decoded mode words: bit 4 says the number is supported
    logic [4:0] wr_dec;
    logic [4:0] cur_dec;

    // Map the printed mode number to an internal mode; unknown numbers are rejected
    function automatic logic [4:0] decode_mode(input logic [7:0] n);
        case (n)
            8'h00: decode_mode = {1'b1, ies_pkg::IES_OFF};
            8'h01: decode_mode = {1'b1, ies_pkg::IES_SINGLE};
            8'h04: decode_mode = {1'b1, ies_pkg::IES_QUAD};
            8'h0B: decode_mode = {1'b1, ies_pkg::IES_ONE_SINGLE};
            8'h0C: decode_mode = {1'b1, ies_pkg::IES_ONE_DOUBLE};
            8'h65: decode_mode = {1'b1, ies_pkg::IES_SINGLE_INV};
            8'h68: decode_mode = {1'b1, ies_pkg::IES_QUAD_INV};
            8'h6F: decode_mode = {1'b1, ies_pkg::IES_ONE_SINGLE_NEG};
            8'h70: decode_mode = {1'b1, ies_pkg::IES_ONE_DOUBLE_NEG};
            default: decode_mode = {1'b0, ies_pkg::IES_OFF};
        endcase
    endfunction

    // Decode once into nets; a select on a call result is not portable
    assign wr_dec = decode_mode(pwdata[7:0]);
    assign cur_dec = decode_mode(mode_raw_r);

    // Write lands in the single access cycle, read data is fetched in setup
    assign wr_en = psel && penable && pwrite;
    assign setup_rd = psel && !penable && !pwrite;

    // Register writes; an out-of-range marks value is refused and the old value kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_raw_r <= ies_pkg::MODE_RESET;
            marks_r <= ies_pkg::MARKS_RESET;
            config_r <= ies_pkg::CONFIG_RESET;
            interval_r <= ies_pkg::INTERVAL_RESET;
        end else if (wr_en) begin
            case (paddr)
                ies_pkg::ADDR_MODE: begin
                    if (wr_dec[4] && pwdata[31:8] == 24'h000000) begin
                        mode_raw_r <= pwdata[7:0];
                    end
                end
                ies_pkg::ADDR_MARKS: begin
                    if (pwdata >= 32'(ies_pkg::MARKS_MIN) && pwdata <= 32'(ies_pkg::MARKS_MAX)) begin
                        marks_r <= pwdata[13:0];
                    end
                end
                ies_pkg::ADDR_CONFIG: config_r <= pwdata[8:0];
                ies_pkg::ADDR_INTERVAL: begin
                    if (pwdata != 32'h00000000) begin
                        interval_r <= pwdata;
                    end
                end
                default: ;
            endcase
        end
    end

    assign mode_ok = cur_dec[4];
    assign mode = ies_pkg::ies_mode_type'(cur_dec[3:0]);

    // Mode properties
    always_comb begin
        cnt_en = 1'b1;
        two_ch = 1'b0;
        factor = 3'h1;
        case (mode)
            ies_pkg::IES_OFF: cnt_en = 1'b0;
            ies_pkg::IES_SINGLE, ies_pkg::IES_SINGLE_INV: two_ch = 1'b1;
            ies_pkg::IES_QUAD, ies_pkg::IES_QUAD_INV: begin
                two_ch = 1'b1;
                factor = 3'h4;
            end
            ies_pkg::IES_ONE_SINGLE, ies_pkg::IES_ONE_SINGLE_NEG: factor = 3'h1;
            ies_pkg::IES_ONE_DOUBLE, ies_pkg::IES_ONE_DOUBLE_NEG: factor = 3'h2;
            default: cnt_en = 1'b0;
        endcase
    end

    // Any two-channel mode claims track B, which covers configs 210/211/230;
    // the configuration number is only stored, so a one-channel mode always frees B
    assign b_used = cnt_en && two_ch;

    // Track sampling; inputs are taken as synchronous
    // One sample per 10 ns clock sees every level of a 150 kHz track many times
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_d_r <= 1'b0;
            b_d_r <= 1'b0;
        end else begin
            a_d_r <= track_a_input;
            b_d_r <= track_b_input;
        end
    end

    assign a_edge = track_a_input ^ a_d_r;
    assign b_edge = track_b_input ^ b_d_r;
    assign a_rise = track_a_input && !a_d_r;

    // Edge step by mode; A leading B is forward
    always_comb begin
        step = 32'sd0;
        case (mode)
            ies_pkg::IES_SINGLE, ies_pkg::IES_SINGLE_INV: begin
                // A rising while B is still low means A leads: forward
                if (a_rise) begin
                    step = track_b_input ? -32'sd1 : 32'sd1;
                end
            end
            ies_pkg::IES_QUAD, ies_pkg::IES_QUAD_INV: begin
                if (a_edge && !b_edge) begin
                    step = (track_a_input ^ track_b_input) ? 32'sd1 : -32'sd1;
                end else if (b_edge && !a_edge) begin
                    step = (track_a_input ^ track_b_input) ? -32'sd1 : 32'sd1;
                end
            end
            ies_pkg::IES_ONE_SINGLE, ies_pkg::IES_ONE_SINGLE_NEG: begin
                if (a_rise) begin
                    step = 32'sd1;
                end
            end
            ies_pkg::IES_ONE_DOUBLE, ies_pkg::IES_ONE_DOUBLE_NEG: begin
                if (a_edge) begin
                    step = 32'sd1;
                end
            end
            default: step = 32'sd0;
        endcase
    end

    // Edge counting over the measurement interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 32'sd0;
            latch_r <= 32'sd0;
            tick_r <= 32'h00000000;
            div_start_r <= 1'b0;
            div_num_r <= 32'h00000000;
            neg_r <= 1'b0;
        end else begin
            div_start_r <= 1'b0;
            if (!cnt_en) begin
                count_r <= 32'sd0;
                tick_r <= 32'h00000000;
            end else if (tick_r >= interval_r - 32'h00000001) begin
                tick_r <= 32'h00000000;
                count_r <= 32'sd0;
                latch_r <= count_r + step;
                // Sign of the step count, inverted or forced per mode
                case (mode)
                    ies_pkg::IES_SINGLE_INV, ies_pkg::IES_QUAD_INV:
                        neg_r <= !((count_r + step) < 0);
                    ies_pkg::IES_ONE_SINGLE_NEG, ies_pkg::IES_ONE_DOUBLE_NEG:
                        neg_r <= 1'b1;
                    ies_pkg::IES_ONE_SINGLE, ies_pkg::IES_ONE_DOUBLE:
                        neg_r <= 1'b0;
                    default: neg_r <= (count_r + step) < 0;
                endcase
                div_num_r <= ((count_r + step) < 0) ? 32'(-(count_r + step))
                                                     : 32'(count_r + step);
                div_start_r <= !div_busy;
            end else begin
                tick_r <= tick_r + 32'h00000001;
                count_r <= count_r + step;
            end
        end
    end

    // Edge count over marks times factor; result in revolutions per interval, Q16
    // Largest divisor is 8192 * 4, which still fits the 16-bit divisor
    // Counts above 65535 per interval wrap: keep the interval short enough
    ies_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start_r),
        .dividend({div_num_r[15:0], 16'h0000}),
        .divisor(16'(marks_r) * 16'(factor)),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    // Speed output and edge gap watch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_out <= 32'h00000000;
            speed_valid <= 1'b0;
            gap_r <= 32'h00000000;
            edge_timeout <= 1'b0;
        end else begin
            speed_valid <= div_done;
            if (div_done) begin
                speed_out <= neg_r ? 32'(-div_q) : div_q;
            end else if (!cnt_en) begin
                speed_out <= 32'h00000000;
            end
            // Flags a track idle longer than the smooth-running limit
            if (!cnt_en || step != 32'sd0) begin
                gap_r <= 32'h00000000;
                edge_timeout <= 1'b0;
            end else if (gap_r >= 32'(ies_pkg::EDGE_GAP_CYC)) begin
                edge_timeout <= 1'b1;
            end else begin
                gap_r <= gap_r + 32'h00000001;
            end
        end
    end

    // Release tracks to other functions when not used by the sensor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            track_a_free <= 1'b1;
            track_b_free <= 1'b1;
            track_a_other <= 1'b0;
            track_b_other <= 1'b0;
        end else begin
            track_a_free <= !cnt_en;
            track_b_free <= !b_used;
            track_a_other <= cnt_en ? 1'b0 : track_a_input;
            track_b_other <= b_used ? 1'b0 : track_b_input;
        end
    end

    // Read data mux
    always_comb begin
        case (paddr)
            ies_pkg::ADDR_MODE: rd_nxt = {24'h000000, mode_raw_r};
            ies_pkg::ADDR_MARKS: rd_nxt = {18'h00000, marks_r};
            ies_pkg::ADDR_CONFIG: rd_nxt = {23'h000000, config_r};
            ies_pkg::ADDR_COUNT: rd_nxt = latch_r;
            ies_pkg::ADDR_SPEED: rd_nxt = speed_out;
            ies_pkg::ADDR_STATUS: rd_nxt = {28'h0000000, mode_ok, edge_timeout, b_used, cnt_en};
            ies_pkg::ADDR_INTERVAL: rd_nxt = interval_r;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // APB answer: zero wait, data registered in setup; unmapped gives error
    // Registered pready gives every access exactly one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > ies_pkg::ADDR_INTERVAL || paddr[1:0] != 2'b00);
            if (setup_rd) begin
                prdata <= rd_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/ies_pkg.sv ====
// Behaviour
// - Track A, B on dedicated inputs
// - Mode 0: no measurement, inputs released
// - Mode 1: direction, one edge per mark
// - Mode 4: direction, four edges per mark
// - Modes 11/12: track A only, positive
// - Modes 101/104 invert sign of 1/4
// - Modes 111/112 one-channel, always negative
// - Configs 210/211/230 give track B to sensor; the config value is only stored, and track B follows the mode
// - One-channel modes leave track B free
// - Marks setting 1..8192, default 1024
// - Track inputs handle up to 150 kHz
// - At least one edge every 2 ms
package ies_pkg;
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_MARKS = 12'h004;
    localparam logic [11:0] ADDR_CONFIG = 12'h008;
    localparam logic [11:0] ADDR_COUNT = 12'h00C;
    localparam logic [11:0] ADDR_SPEED = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_INTERVAL = 12'h018;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [13:0] MARKS_MIN = 14'h0001;
    localparam logic [13:0] MARKS_MAX = 14'h2000;
    localparam logic [13:0] MARKS_RESET = 14'h0400;
    localparam logic [8:0] CONFIG_RESET = 9'h000;
    localparam int CLK_HZ = 100000000;
    localparam int FMAX_HZ = 150000;
    localparam int EDGE_GAP_US = 2000;
    localparam int EDGE_GAP_CYC = (CLK_HZ / 1000000) * EDGE_GAP_US;
    localparam int HALF_PER_MIN_CYC = (CLK_HZ + 2 * FMAX_HZ - 1) / (2 * FMAX_HZ);
    localparam logic [31:0] INTERVAL_RESET = 32'h000F4240;
    typedef enum logic [3:0] {
        IES_OFF = 4'b0000,
        IES_SINGLE = 4'b0001,
        IES_QUAD = 4'b0010,
        IES_ONE_SINGLE = 4'b0011,
        IES_ONE_DOUBLE = 4'b0100,
        IES_SINGLE_INV = 4'b0101,
        IES_QUAD_INV = 4'b0110,
        IES_ONE_SINGLE_NEG = 4'b0111,
        IES_ONE_DOUBLE_NEG = 4'b1000
    } ies_mode_type;
endpackage

// ==== verilog/ies_div.sv ====
`timescale 1ns/1ps
`default_nettype none
// Sequential restoring divider, 32 by 16 bits, one quotient bit per cycle
module ies_div (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    // Answer
    output logic busy,
    output logic done,
    output logic [31:0] quotient
);
    logic [31:0] rem_r;
    logic [31:0] quo_r;
    logic [5:0] cnt_r;
    logic [32:0] trial;

    // Shift-subtract step; divisor zero yields all ones
    always_comb begin
        trial = {rem_r, quo_r[31]} - {17'h00000, divisor};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_r <= 32'h00000000;
            quo_r <= 32'h00000000;
            cnt_r <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= 32'h00000000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_r <= 32'h00000000;
                quo_r <= dividend;
                cnt_r <= 6'h20;
                busy <= 1'b1;
            end else if (busy) begin
                if (!trial[32]) begin
                    rem_r <= trial[31:0];
                    quo_r <= {quo_r[30:0], 1'b1};
                end else begin
                    rem_r <= {rem_r[30:0], quo_r[31]};
                    quo_r <= {quo_r[30:0], 1'b0};
                end
                cnt_r <= cnt_r - 6'h01;
                if (cnt_r == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= !trial[32] ? {quo_r[30:0], 1'b1} : {quo_r[30:0], 1'b0};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/ies_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the APB handshake, track release outputs and speed pulse of ies_top
module ies_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Tracks
    input wire logic track_a_input,
    input wire logic track_a_free,
    input wire logic track_b_free,
    input wire logic track_a_other,
    input wire logic track_b_other,
    // Speed
    input wire logic speed_valid
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Setup cycle followed by the access cycle
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    // Track A released and quiet long enough for the registered copy to settle
    sequence s_a_quiet;
        (track_a_free && $stable(track_a_input))[*4];
    endsequence
    a_ready_in_access: assert property (s_access |-> pready)
        else $error("pready missing in access phase");
    a_ready_only_access: assert property (pready |-> psel && penable && $past(psel && !penable))
        else $error("pready outside an access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property ((paddr > 12'h018 || paddr[1:0] != 2'h0) ##0 s_access
        |-> pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property ((paddr <= 12'h018 && paddr[1:0] == 2'h0) ##0 s_access
        |-> !pslverr)
        else $error("mapped access refused");
    a_valid_one_cycle: assert property (speed_valid |=> !speed_valid)
        else $error("speed_valid longer than one cycle");
    a_b_freed_first: assert property (track_a_free |-> track_b_free)
        else $error("track A released while track B claimed");
    a_b_other_quiet: assert property (!track_b_free && $past(!track_b_free) |-> !track_b_other)
        else $error("track B copy shown while claimed");
    a_a_copy_follows: assert property (s_a_quiet |-> track_a_other == track_a_input)
        else $error("released track A copy wrong");
endmodule
bind ies_top ies_checker u_ies_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .track_a_input(track_a_input),
    .track_a_free(track_a_free), .track_b_free(track_b_free), .track_a_other(track_a_other),
    .track_b_other(track_b_other), .speed_valid(speed_valid)
);
`default_nettype wire

// ==== sim/ies_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Quadrature encoder stepping through four track states at a fixed pace
module ies_encoder_model #(
    parameter int QUARTER_CYC = 175
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Motion control
    input wire logic run,
    input wire logic reverse,
    // Tracks
    output logic track_a,
    output logic track_b
);
    int pace_r;
    logic [1:0] phase_r;
    // Half period of 350 cycles keeps each track below the input limit,
    // and an edge every 175 cycles is far inside the minimum edge rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_r <= 0;
            phase_r <= 2'h0;
        end else if (run) begin
            if (pace_r == QUARTER_CYC - 1) begin
                pace_r <= 0;
                phase_r <= reverse ? phase_r - 2'h1 : phase_r + 2'h1;
            end else begin
                pace_r <= pace_r + 1;
            end
        end
    end
    // Gray order 00,10,11,01: track A leads track B when going forward
    assign track_a = phase_r == 2'h1 || phase_r == 2'h2;
    assign track_b = phase_r[1];
endmodule
`default_nettype wire

// ==== sim/ies_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: APB master tasks, encoder partner, one task per scenario
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic enc_run = 1'b1;
    logic enc_rev = 1'b0;
    logic [31:0] prdata, speed_out, rd;
    logic pready, pslverr, enc_a, enc_b, a_free, b_free, a_other, b_other;
    logic speed_valid, edge_timeout, err;
    int n_mismatch = 0;
    int checks_done = 0;

    ies_top u_ies_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .track_a_input(enc_a), .track_b_input(enc_b), .track_a_free(a_free),
        .track_b_free(b_free), .track_a_other(a_other), .track_b_other(b_other),
        .speed_out(speed_out), .speed_valid(speed_valid), .edge_timeout(edge_timeout)
    );
    ies_encoder_model u_ies_encoder_model (
        .pclk(pclk), .presetn(presetn), .run(enc_run), .reverse(enc_rev),
        .track_a(enc_a), .track_b(enc_b)
    );
    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic hang(input string what);
        n_mismatch++;
        $display("ERROR %s expected response seen timeout", what);
        complete_run();
    endtask
    // Case inequality so that an unknown never counts as a match
    task automatic check32(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    // One APB transfer; the leading edge keeps two transfers from driving in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!(pready === 1'b1 && penable === 1'b1) && n < 20);
        if (pready !== 1'b1 || penable !== 1'b1) hang("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] w, input logic [31:0] e);
        apb(1'b1, a, w);
        apb(1'b0, a, 32'h00000000);
        check32("register readback", e, rd);
    endtask
    task automatic wait_valid();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (speed_valid !== 1'b1 && n < 5000);
        if (speed_valid !== 1'b1) hang("speed_valid");
    endtask
    task automatic test_reset_values();
        int n;
        logic prev;
        check32("track a released", 32'h00000001, {31'h0, a_free});
        check32("track b released", 32'h00000001, {31'h0, b_free});
        wr_rd(ies_pkg::ADDR_MODE, 32'h00000005, 32'h00000000);
        apb(1'b0, ies_pkg::ADDR_MARKS, 32'h00000000);
        check32("marks reset", 32'h00000400, rd);
        apb(1'b0, ies_pkg::ADDR_INTERVAL, 32'h00000000);
        check32("interval reset", 32'h000F4240, rd);
        apb(1'b0, 12'h01C, 32'h00000000);
        check32("unmapped error", 32'h00000001, {31'h0, err});
        n = 0;
        prev = enc_a;
        while (enc_a === prev && n < 800) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 800) hang("track a edge");
        repeat (10) @(posedge pclk);
        check32("track a copy", {31'h0, enc_a}, {31'h0, a_other});
        check32("track b copy", {31'h0, enc_b}, {31'h0, b_other});
        $display("test reset values done");
    endtask
    // Range edges of the marks setting, then a two-period measurement interval
    task automatic test_marks();
        wr_rd(ies_pkg::ADDR_MARKS, 32'h00000000, 32'h00000400);
        wr_rd(ies_pkg::ADDR_MARKS, 32'h00002001, 32'h00000400);
        wr_rd(ies_pkg::ADDR_MARKS, 32'h00002000, 32'h00002000);
        wr_rd(ies_pkg::ADDR_MARKS, 32'h00000001, 32'h00000001);
        wr_rd(ies_pkg::ADDR_MARKS, 32'h00000002, 32'h00000002);
        wr_rd(ies_pkg::ADDR_INTERVAL, 32'h00000578, 32'h00000578);
        wr_rd(ies_pkg::ADDR_INTERVAL, 32'h00000000, 32'h00000578);
        wr_rd(ies_pkg::ADDR_CONFIG, 32'h000000D3, 32'h000000D3);
        wr_rd(ies_pkg::ADDR_CONFIG, 32'h000000E6, 32'h000000E6);
        wr_rd(ies_pkg::ADDR_CONFIG, 32'h000000D2, 32'h000000D2);
        $display("test marks and config done");
    endtask
    // Third pulse covers a full interval in the new mode; 1400 cycles hold two periods
    // The count register keeps the raw edge count; only the speed carries the mode's sign
    task automatic run_mode(input logic [31:0] m, input logic rev, input logic [31:0] c,
        input logic neg, input logic b_rel);
        logic [31:0] sp;
        enc_rev <= rev;
        apb(1'b1, ies_pkg::ADDR_MODE, m);
        wait_valid();
        wait_valid();
        wait_valid();
        sp = speed_out;
        apb(1'b0, ies_pkg::ADDR_COUNT, 32'h00000000);
        check32("edge count", c, rd);
        check32("speed", neg ? 32'hFFFF0000 : 32'h00010000, sp);
        check32("track b released", {31'h0, b_rel}, {31'h0, b_free});
        check32("track a released", 32'h00000000, {31'h0, a_free});
        check32("edge timeout", 32'h00000000, {31'h0, edge_timeout});
        $display("mode %0d done", m);
    endtask
    task automatic test_modes();
        run_mode(32'h00000001, 1'b0, 32'h00000002, 1'b0, 1'b0);
        run_mode(32'h00000004, 1'b0, 32'h00000008, 1'b0, 1'b0);
        run_mode(32'h00000004, 1'b1, 32'hFFFFFFF8, 1'b1, 1'b0);
        run_mode(32'h00000065, 1'b0, 32'h00000002, 1'b1, 1'b0);
        run_mode(32'h00000068, 1'b0, 32'h00000008, 1'b1, 1'b0);
        run_mode(32'h0000000B, 1'b0, 32'h00000002, 1'b0, 1'b1);
        run_mode(32'h0000000C, 1'b1, 32'h00000004, 1'b0, 1'b1);
        run_mode(32'h0000006F, 1'b0, 32'h00000002, 1'b1, 1'b1);
        run_mode(32'h00000070, 1'b1, 32'h00000004, 1'b1, 1'b1);
        wr_rd(ies_pkg::ADDR_MODE, 32'h00000000, 32'h00000000);
        check32("track a released", 32'h00000001, {31'h0, a_free});
        check32("track b released", 32'h00000001, {31'h0, b_free});
        $display("test modes done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_values();
        test_marks();
        test_modes();
        complete_run();
    end
endmodule
`default_nettype wire
